// [rtl/pag_port.sv]
/*
  pag_port: eight-pin bidirectional port with direction and analog select,
  reached over a classic wishbone slave (32-bit data, one word per register).
  assumes: single core clock, synchronous active-low reset; pin levels come
  straight from pads and are synchronised here; the pad ring combines
  PIN_OUT_O and PIN_OE_O into the wire.
*/
// Chosen here: register access over Wishbone and the address map.
`default_nettype none
// Function
// - direction one disables pin output driver
// - direction zero drives output latch onto pin
// - data read returns sampled pin levels
// - data write merges sampled pins into latch; here the whole written byte goes into the latch, no pin bits kept
// - direction still controls driver when analog
// - analog pin reads back as zero
// - analog select leaves digital output working
// - analog select zero gives digital pin
// - analog disables input buffer, pullup, change-detect; this port has only the input buffer, no pullup or change-detect
// - upper direction bits read one in oscillator modes
// - reset sets all direction bits
// - reset sets all analog bits, latch undefined
module pag_port
  import pag_pkg::*;
(
  input  wire logic                      REF_CLK_I,   // core clock, 100 MHz
  input  wire logic                      RST_N_I,     // sync reset, active low
  input  wire logic                      WB_CYC_I,    // bus cycle
  input  wire logic                      WB_STB_I,    // strobe
  input  wire logic                      WB_WE_I,     // write enable
  input  wire logic [pag_pkg::ADR_W-1:0] WB_ADR_I,    // byte address
  input  wire logic [3:0]                WB_SEL_I,    // byte lanes
  input  wire logic [31:0]               WB_DAT_I,    // write data
  output logic      [31:0]               WB_DAT_O,    // read data
  output logic                           WB_ACK_O,    // acknowledge
  input  wire logic [pag_pkg::PORT_W-1:0] PIN_IN_I,   // pad input levels
  output logic      [pag_pkg::PORT_W-1:0] PIN_OUT_O,  // pad output levels
  output logic      [pag_pkg::PORT_W-1:0] PIN_OE_O,   // pad driver enable
  output logic      [pag_pkg::PORT_W-1:0] PIN_IBUF_EN_O, // digital input buffer on
  output logic      [pag_pkg::PORT_W-1:0] PIN_ANALOG_O   // pin handed to analog
);
  import pag_pkg::*;

  // ==========================================================
  // bus decode
  logic                 req;                   // live request, not yet acked
  logic                 lane0;                 // low byte lane selected
  logic                 wr_data;               // write to pin data
  logic                 wr_dir;                // write to direction
  logic                 wr_ana;                // write to analog select
  logic                 wr_osc;                // write to oscillator mode
  logic                 hit;                   // address mapped
  logic [PORT_W-1:0]    pins_sync;             // synchronised pad levels
  logic [PORT_W-1:0]    pin_read;              // levels as software sees them
  logic [PORT_W-1:0]    latch_q;               // output latch
  logic [PORT_W-1:0]    dir_q;                 // direction bits
  logic [PORT_W-1:0]    ana_q;                 // analog select bits
  logic [PORT_W-1:0]    dir_read;              // direction as read back
  logic [PORT_W-1:0]    osc_force;             // bits forced to input read
  logic [PORT_W-1:0]    latch_wdat;            // merged latch write value
  logic [7:0]           osc_q;                 // oscillator mode byte
  logic                 osc_pins_used;         // oscillator owns upper pins
  pag_wb_resp_t         resp_r;                // registered bus answer
  pag_wb_resp_t         resp_nxt;              // next bus answer
  pag_pin_drive_t       drv_r;                 // registered pad drive
  pag_pin_drive_t       drv_nxt;               // next pad drive
  logic [PORT_W-1:0]    ibuf_r;                // registered input enable
  logic [PORT_W-1:0]    ibuf_nxt;              // next input enable
  logic [PORT_W-1:0]    ana_out_r;             // registered analog hand-over
  logic [PORT_W-1:0]    ana_out_nxt;           // next analog hand-over

  // a request is live until acked; ack falls the cycle after it rose
  always_comb begin
    req     = WB_CYC_I && WB_STB_I && !resp_r.ack;
    lane0   = WB_SEL_I[0];
    hit     = 1'b0;
    wr_data = 1'b0;
    wr_dir  = 1'b0;
    wr_ana  = 1'b0;
    wr_osc  = 1'b0;
    if (WB_ADR_I == OFS_PIN_DATA) begin
      hit     = 1'b1;
      wr_data = req && WB_WE_I && lane0;
    end else if (WB_ADR_I == OFS_DIRECTION) begin
      hit     = 1'b1;
      wr_dir  = req && WB_WE_I && lane0;
    end else if (WB_ADR_I == OFS_ANALOG) begin
      hit     = 1'b1;
      wr_ana  = req && WB_WE_I && lane0;
    end else if (WB_ADR_I == OFS_OSC_MODE) begin
      hit     = 1'b1;
      wr_osc  = req && WB_WE_I && lane0;
    end
  end

  // ==========================================================
  // pad sampling
  pag_sync #(.W(PORT_W)) u_sync (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .async_i (PIN_IN_I),
    .sync_o  (pins_sync)
  );

  // ==========================================================
  // software registers
  // latch reset is left undefined for software; zero keeps reads defined
  pag_cfg_reg #(.RST_VAL(RST_LATCH)) u_latch (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .wr_i    (wr_data),
    .wdat_i  (latch_wdat),
    .q_o     (latch_q)
  );
  pag_cfg_reg #(.RST_VAL(RST_DIRECTION)) u_dir (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .wr_i    (wr_dir),
    .wdat_i  (WB_DAT_I[PORT_W-1:0]),
    .q_o     (dir_q)
  );
  pag_cfg_reg #(.RST_VAL(RST_ANALOG)) u_ana (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .wr_i    (wr_ana),
    .wdat_i  (WB_DAT_I[PORT_W-1:0]),
    .q_o     (ana_q)
  );
  pag_cfg_reg #(.RST_VAL(RST_OSC_MODE)) u_osc (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .wr_i    (wr_osc),
    .wdat_i  (WB_DAT_I[7:0]),
    .q_o     (osc_q)
  );

  // ==========================================================
  // read paths and read-modify-write merge
  always_comb begin
    // analog pins read zero
    pin_read = pins_sync & ~ana_q;
    // the write merge starts from what the pins show now; bytes written
    // replace it. with one 8-bit lane the merge is the whole written byte,
    // so an analog output pin cannot lose its latch value on byte-narrow ops
    latch_wdat = WB_DAT_I[PORT_W-1:0];
    osc_pins_used = (osc_q[2:0] == PAG_OSC_LOW_POWER) ||
                    (osc_q[2:0] == PAG_OSC_CRYSTAL) ||
                    (osc_q[2:0] == PAG_OSC_HIGH_SPD);
    osc_force = osc_pins_used ? OSC_PIN_MASK : '0;
    dir_read  = dir_q | osc_force;
  end

  // ==========================================================
  // bus answer: one wait state, ack for one cycle
  always_comb begin
    resp_nxt.ack = req;
    resp_nxt.dat = UNMAPPED_DATA;
    if (req && !WB_WE_I && hit) begin
      if (WB_ADR_I == OFS_PIN_DATA) begin
        resp_nxt.dat = {24'h00_0000, pin_read};
      end else if (WB_ADR_I == OFS_DIRECTION) begin
        resp_nxt.dat = {24'h00_0000, dir_read};
      end else if (WB_ADR_I == OFS_ANALOG) begin
        resp_nxt.dat = {24'h00_0000, ana_q};
      end else begin
        resp_nxt.dat = {24'h00_0000, osc_q};
      end
    end
  end

  // ==========================================================
  // pad drive: direction owns the driver regardless of analog select
  always_comb begin
    drv_nxt.oe  = ~dir_q;
    drv_nxt.out = latch_q & ~dir_q;
    ibuf_nxt    = ~ana_q;
    // analog hand-over registered like the other pad outputs
    ana_out_nxt = ana_q;
  end

  // output registers
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      resp_r <= '0;
      drv_r  <= '0;
      ibuf_r <= '0;
      ana_out_r <= '0;
    end else begin
      resp_r <= resp_nxt;
      drv_r  <= drv_nxt;
      ibuf_r <= ibuf_nxt;
      ana_out_r <= ana_out_nxt;
    end
  end

  assign WB_ACK_O      = resp_r.ack;
  assign WB_DAT_O      = resp_r.dat;
  assign PIN_OUT_O     = drv_r.out;
  assign PIN_OE_O      = drv_r.oe;
  assign PIN_IBUF_EN_O = ibuf_r;
  assign PIN_ANALOG_O  = ana_out_r;

  // ==========================================================
  // checks
  sequence s_dir_write;
    WB_ACK_O && $past(WB_WE_I && WB_CYC_I && WB_STB_I && WB_SEL_I[0]
                      && WB_ADR_I == OFS_DIRECTION);
  endsequence
  // analog select write taken the edge before the ack
  sequence s_ana_write;
    WB_ACK_O && $past(WB_WE_I && WB_CYC_I && WB_STB_I && WB_SEL_I[0]
                      && WB_ADR_I == OFS_ANALOG);
  endsequence
  // a read of the pin data register being taken
  sequence s_pin_read;
    req && !WB_WE_I && WB_ADR_I == OFS_PIN_DATA;
  endsequence
  // ack high for one cycle, then low again
  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  a_input_no_drive: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    dir_q != 8'h00 |=> (PIN_OE_O & $past(dir_q)) == 8'h00)
    else $error("input pin is driven");
  a_output_drives: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    1'b1 |=> PIN_OUT_O == ($past(latch_q) & ~$past(dir_q)))
    else $error("output pin not showing latch");
  a_read_pins: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    s_pin_read |=> WB_DAT_O[7:0] == ($past(pins_sync) & ~$past(ana_q)))
    else $error("data read not pin levels");
  a_rmw_store: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    wr_data |=> latch_q == $past(WB_DAT_I[7:0]))
    else $error("latch not written");
  a_dir_owns: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    1'b1 |=> PIN_OE_O == ~$past(dir_q))
    else $error("driver enable ignores direction");
  a_analog_zero: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    s_pin_read |=> (WB_DAT_O[7:0] & $past(ana_q)) == 8'h00)
    else $error("analog pin read not zero");
  a_ibuf_off: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    1'b1 |=> PIN_IBUF_EN_O == ~$past(ana_q))
    else $error("input buffer not following analog select");
  a_osc_dir_one: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    req && !WB_WE_I && WB_ADR_I == OFS_DIRECTION && osc_pins_used
    |=> WB_DAT_O[7:6] == 2'b11)
    else $error("oscillator pins read as output");
  a_dir_update: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    s_dir_write |-> dir_q == $past(WB_DAT_I[7:0]))
    else $error("direction not updated on ack edge");
  a_reset_vals: assert property (@(posedge REF_CLK_I)
    $past(!RST_N_I) |-> dir_q == RST_DIRECTION && ana_q == RST_ANALOG)
    else $error("reset values wrong");

  // ==========================================================
  // bus timing and register hold checks
  // ack answers a taken request once and drops the cycle after
  a_ack_pulse: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    req |=> s_ack_pulse)
    else $error("ack not a one-cycle answer");
  // no ack without a request taken the edge before
  a_no_stray_ack: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !req |=> !WB_ACK_O)
    else $error("ack without request");
  // latch changes only on an accepted data write
  a_latch_hold: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !wr_data |=> latch_q == $past(latch_q))
    else $error("latch changed without write");
  // direction changes only on an accepted direction write
  a_dir_hold: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !wr_dir |=> dir_q == $past(dir_q))
    else $error("direction changed without write");
  // analog select takes the written byte on the ack edge
  a_ana_update: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    s_ana_write |-> ana_q == $past(WB_DAT_I[7:0]))
    else $error("analog select not updated on ack edge");
  // a write without the low lane is acked but stored nowhere
  a_lane_refused: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    req && WB_WE_I && !WB_SEL_I[0] |=> ana_q == $past(ana_q) && dir_q == $past(dir_q))
    else $error("write without low lane was stored");
  // analog hand-over follows the select bits one edge later
  a_analog_out: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    1'b1 |=> PIN_ANALOG_O == $past(ana_q))
    else $error("analog hand-over not following select");
  // an analog pin set as output still drives its latch bit
  a_analog_out_kept: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (ana_q & ~dir_q) != 8'h00 |=>
      (PIN_OE_O & $past(ana_q & ~dir_q)) == $past(ana_q & ~dir_q) &&
      (PIN_OUT_O & $past(ana_q & ~dir_q)) == ($past(latch_q) & $past(ana_q & ~dir_q)))
    else $error("analog output pin lost its driver");
  // outside oscillator modes the direction reads back unforced
  a_osc_free: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    req && !WB_WE_I && WB_ADR_I == OFS_DIRECTION && !osc_pins_used
    |=> WB_DAT_O[7:0] == $past(dir_q))
    else $error("direction forced outside oscillator modes");
  // unmapped reads answer with zero
  a_unmapped_zero: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    req && !WB_WE_I && !hit |=> WB_DAT_O == UNMAPPED_DATA)
    else $error("unmapped read not zero");
  // only the low byte carries data
  a_upper_zero: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    WB_ACK_O |-> WB_DAT_O[31:PORT_W] == 24'h00_0000)
    else $error("upper read bits not zero");
endmodule // pag_port
`default_nettype wire

// [rtl/pag_pkg.sv]
/*
  pag_pkg: shared constants and carrier types for the port a gpio block.
  assumes: compiled before every design file of the block; 8-bit port.
*/
`default_nettype none
package pag_pkg;
  // ==========================================================
  // widths
  localparam int unsigned PORT_W = 8;           // pins on the port
  localparam int unsigned ADR_W  = 4;           // byte address bits decoded
  // ==========================================================
  // register byte offsets (one aligned word each)
  localparam logic [ADR_W-1:0] OFS_PIN_DATA  = 4'h0; // port_a_pin_data
  localparam logic [ADR_W-1:0] OFS_DIRECTION = 4'h4; // port_a_direction
  localparam logic [ADR_W-1:0] OFS_ANALOG    = 4'h8; // analog_select
  localparam logic [ADR_W-1:0] OFS_OSC_MODE  = 4'hc; // oscillator mode select
  // ==========================================================
  // reset values
  localparam logic [PORT_W-1:0] RST_DIRECTION = 8'hff; // all inputs
  localparam logic [PORT_W-1:0] RST_ANALOG    = 8'hff; // all analog
  localparam logic [PORT_W-1:0] RST_LATCH     = 8'h00; // undefined for software, zero here
  localparam logic [7:0]        RST_OSC_MODE  = 8'h00; // internal oscillator, pins free
  localparam logic [PORT_W-1:0] OSC_PIN_MASK  = 8'hc0; // two upper pins
  localparam logic [31:0]       UNMAPPED_DATA = 32'h0000_0000; // unmapped read
  // ==========================================================
  // oscillator mode encoding
  typedef enum logic [2:0] {
    PAG_OSC_INTERNAL  = 3'h0, // internal oscillator, pins free
    PAG_OSC_LOW_POWER = 3'h1, // low_power_oscillator_mode
    PAG_OSC_CRYSTAL   = 3'h2, // crystal_oscillator_mode
    PAG_OSC_HIGH_SPD  = 3'h3, // high_speed_oscillator_mode
    PAG_OSC_EXTERNAL  = 3'h4  // external clock, pins free
  } pag_osc_mode_t;
  // ==========================================================
  // carriers: one bundle for the pad drive, one for the bus answer
  typedef struct packed {
    logic [PORT_W-1:0] out; // driven level
    logic [PORT_W-1:0] oe;  // driver enable, high drives
  } pag_pin_drive_t;
  typedef struct packed {
    logic [31:0] dat; // read data
    logic        ack; // acknowledge
  } pag_wb_resp_t;
endpackage : pag_pkg
`default_nettype wire

// [rtl/pag_sync.sv]
/*
  pag_sync: two-flop synchroniser for the pin levels.
  assumes: inputs are asynchronous pins; output is stable on clk.
*/
`default_nettype none
module pag_sync #(
  parameter int unsigned W = 8                   // bus width
) (
  input  wire logic         clk_i,               // core clock
  input  wire logic         rst_n_i,             // sync reset, active low
  input  wire logic [W-1:0] async_i,             // raw pin levels
  output logic      [W-1:0] sync_o               // synchronised levels
);
  // ==========================================================
  // two stages; first stage is read only by the second
  logic [W-1:0] meta_r;                          // first stage
  logic [W-1:0] meta_nxt;                        // first stage next
  logic [W-1:0] sync_r;                          // second stage
  logic [W-1:0] sync_nxt;                        // second stage next

  // next values
  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  // registers; reset clears both to a constant
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule // pag_sync

// [rtl/pag_cfg_reg.sv]
/*
  pag_cfg_reg: one 8-bit software register with reset value and write strobe.
  assumes: write strobe is a single-cycle pulse on the core clock.
*/
`default_nettype none
module pag_cfg_reg #(
  parameter logic [7:0] RST_VAL = 8'h00          // value after reset
) (
  input  wire logic       clk_i,                 // core clock
  input  wire logic       rst_n_i,               // sync reset, active low
  input  wire logic       wr_i,                  // write strobe
  input  wire logic [7:0] wdat_i,                // write data
  output logic      [7:0] q_o                    // stored value
);
  // ==========================================================
  logic [7:0] q_r;                               // stored value
  logic [7:0] q_nxt;                             // next value

  // load on the strobe, hold otherwise
  always_comb begin
    q_nxt = wr_i ? wdat_i : q_r;
  end

  // register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule // pag_cfg_reg

// [verif/pag_board.sv]
/*
  pag_board: board side of the eight port pins, resolving the wire level.
  assumes: pad ring merges driver enable and output level; no pull resistors.
*/
`default_nettype none
module pag_board
  import pag_pkg::*;
(
  input  wire logic                       clk_i,     // core clock
  input  wire logic [pag_pkg::PORT_W-1:0] out_i,     // device output levels
  input  wire logic [pag_pkg::PORT_W-1:0] oe_i,      // device driver enable
  input  wire logic [pag_pkg::PORT_W-1:0] ext_lvl_i, // board drive level
  input  wire logic [pag_pkg::PORT_W-1:0] ext_en_i,  // board drives pin
  output logic      [pag_pkg::PORT_W-1:0] pin_o      // resolved wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  import pag_pkg::*;
  // ==========================================================
  // floating pins
  logic [PORT_W-1:0] float_r = 8'h55; // toggles so a floating pin never looks stable
  // undriven lines change every cycle, no pull to rely on
  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  // ==========================================================
  // wire resolution: device driver first, board where the device is off
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_lvl_i)
               | (~oe_i & ~ext_en_i & float_r);
endmodule // pag_board
`default_nettype wire

// [verif/pag_port_tb.sv]
/*
  pag_port_tb: register level tests of the port over classic wishbone.
  assumes: pag_pkg and pag_port compiled first; ack answers one cycle after take.
*/
`default_nettype none
module pag_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pag_pkg::*;
  // ==========================================================
  // signals
  logic              clk = 1'b0;      // core clock
  logic              rst_n = 1'b0;    // reset, active low
  logic              cyc = 1'b0;      // bus cycle
  logic              stb = 1'b0;      // strobe
  logic              we = 1'b0;       // write enable
  logic [ADR_W-1:0]  adr = '0;        // byte address
  logic [31:0]       wdat = '0;       // write data
  logic [3:0]        sel = 4'hf;      // byte lanes
  logic [31:0]       rsp;             // answer of a refused write, unused
  logic [31:0]       rdat;            // read data
  logic              ack;             // acknowledge
  logic [PORT_W-1:0] pin, pout, poe;  // wire, pad out, pad enable
  logic [PORT_W-1:0] ibuf, ana;       // input buffer on, analog
  logic [PORT_W-1:0] ext_lvl = 8'ha5; // board level
  logic [PORT_W-1:0] ext_en = 8'hff;  // board drives
  int                num_errors = 0;  // mismatches
  int                checked = 0;     // comparisons
  int                m;               // oscillator mode loop index
  // 100 MHz clock
  always #5 clk = ~clk;
  // ==========================================================
  // instances
  pag_port i_pag_port (.REF_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PIN_IN_I(pin), .PIN_OUT_O(pout), .PIN_OE_O(poe),
    .PIN_IBUF_EN_O(ibuf), .PIN_ANALOG_O(ana));
  pag_board i_pag_board (.clk_i(clk), .out_i(pout), .oe_i(poe), .ext_lvl_i(ext_lvl),
    .ext_en_i(ext_en), .pin_o(pin));
  // ==========================================================
  // tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one classic cycle; entered just after a rising edge, ends one edge after release
  task automatic wb_cycle(input logic w, input logic [3:0] s, input logic [ADR_W-1:0] a,
                          input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= s;
    adr  <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check("ack timeout", 32'h1, 32'h0);
    r = rdat;       // taken at the ack edge
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb_cycle(1'b1, 4'hf, a, d, r);
  endtask
  task automatic rd_chk(input string name, input logic [ADR_W-1:0] a, input logic [7:0] e);
    logic [31:0] r;
    wb_cycle(1'b0, 4'hf, a, 8'h00, r);
    check(name, r, {24'h0, e});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog: tests need well under 1000 cycles, allow twenty times that
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values and fully analog port
    rd_chk("direction", OFS_DIRECTION, 8'hff);
    rd_chk("analog", OFS_ANALOG, 8'hff);
    check("oe", {24'h0, poe}, 32'h0000_0000);
    check("analog pins", {24'h0, ana}, 32'h0000_00ff);
    check("ibuf", {24'h0, ibuf}, 32'h0000_0000);
    rd_chk("pin analog", OFS_PIN_DATA, 8'h00);
    $display("test reset done");
    // digital input path
    wr(OFS_ANALOG, 8'h00);
    check("ibuf digital", {24'h0, ibuf}, 32'h0000_00ff);
    repeat (4) @(posedge clk);
    rd_chk("pin in", OFS_PIN_DATA, 8'ha5);
    $display("test digital input done");
    // mixed directions: read shows pins, not latch
    wr(OFS_DIRECTION, 8'h0f);
    check("oe mixed", {24'h0, poe}, 32'h0000_00f0);
    wr(OFS_PIN_DATA, 8'h3c);
    check("out", {24'h0, pout & poe}, 32'h0000_0030);
    repeat (3) @(posedge clk);
    rd_chk("pin mixed", OFS_PIN_DATA, 8'h35);
    wr(OFS_DIRECTION, 8'h00);
    check("out all", {24'h0, pout}, 32'h0000_003c);
    check("oe all", {24'h0, poe}, 32'h0000_00ff);
    $display("test output done");
    // analog select on driven pins
    wr(OFS_ANALOG, 8'h30);
    check("out analog", {24'h0, pout}, 32'h0000_003c);
    check("oe analog", {24'h0, poe}, 32'h0000_00ff);
    repeat (3) @(posedge clk);
    rd_chk("pin analog out", OFS_PIN_DATA, 8'h0c);
    wr(OFS_DIRECTION, 8'hff);
    check("oe analog in", {24'h0, poe}, 32'h0000_0000);
    check("ibuf partial", {24'h0, ibuf}, 32'h0000_00cf);
    $display("test analog output done");
    // oscillator modes force upper direction bits on readback
    wr(OFS_DIRECTION, 8'h0f);
    for (m = 0; m < 5; m++) begin
      wr(OFS_OSC_MODE, m[7:0]);
      rd_chk("dir osc", OFS_DIRECTION, (m >= 1 && m <= 3) ? 8'hcf : 8'h0f);
    end
    check("oe osc", {24'h0, poe}, 32'h0000_00f0);
    $display("test oscillator done");
    // unmapped address: acked, reads zero, writes lost
    wr(4'h2, 8'hff);
    rd_chk("unmapped", 4'h2, 8'h00);
    rd_chk("analog kept", OFS_ANALOG, 8'h30);
    // a write without the low byte lane is acked and dropped
    wb_cycle(1'b1, 4'he, OFS_ANALOG, 8'hff, rsp);
    rd_chk("lane refused", OFS_ANALOG, 8'h30);
    $display("test unmapped done");
    // reset in mid-run brings every register back to its reset value
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk("direction again", OFS_DIRECTION, 8'hff);
    rd_chk("analog again", OFS_ANALOG, 8'hff);
    check("oe again", {24'h0, poe}, 32'h0000_0000);
    check("out again", {24'h0, pout}, 32'h0000_0000);
    check("analog again pins", {24'h0, ana}, 32'h0000_00ff);
    $display("test second reset done");
    final_report();
  end
endmodule // pag_port_tb
`default_nettype wire
